/* File: fcs_host.v */
// Host controller issuing command sequences to a banked NOR flash
// Assumes software on classic Wishbone; flash on plain pins, inputs synchronous
// Operation
// R1 - Autoselect: two unlocks, bank command
// R2 - Autoselect only when no bank busy
// R3 - Autoselect reads repeat without re-entry
// R4 - Protection query uses bank and sector
// R5 - Reset command leaves autoselect
// R6 - Three-cycle secure entry, four-cycle exit
// R7 - Secure region denied while busy
// R8 - No bypass or acceleration while secured
// R9 - Program: two unlocks, setup, address data
// R10 - Program done shown on ready busy
// R11 - Commands ignored while programming
// R12 - Secure and autoselect unavailable during program
// R13 - Programming clears bits only
// R14 - Program in any address order
// R15 - Bypass entry: two unlocks then 20h
// R16 - Bypass program: A0h then address data
// R17 - Bypass accepts only program and reset
// R18 - High voltage enters accelerated bypass
// R19 - Chip erase: six write cycles
// R20 - Erase preprograms internally, host idle
// R21 - Erase done shown on ready busy
// R22 - Commands ignored during chip erase
// R23 - Address on falling, data on rising
// R24 - Reset between program cycles aborts
// R25 - Time-limit flag needs reset command
// R26 - Mismatched cycle abandons the sequence
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "fcs_map.vh"
module fcs_host (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg         wb_ack_o,
  output wire [21:0] fl_addr_o,
  output wire [15:0] fl_dq_o,
  output wire        fl_dq_oe_o,
  input  wire [15:0] fl_dq_i,
  output wire        fl_ce_n_o,
  output wire        fl_we_n_o,
  output wire        fl_oe_n_o,
  output wire        fl_byte_n_o,
  output reg         protect_accel_pin_o,
  output reg         fl_reset_n_o,
  input  wire        ready_busy_output_i
);
  localparam S_IDLE = 4'b0001;
  localparam S_LOAD = 4'b0010;
  localparam S_CYC  = 4'b0100;
  localparam S_WAIT = 4'b1000;

  reg  [3:0]  state;
  reg  [3:0]  op;
  reg  [2:0]  step;
  reg  [2:0]  nsteps;
  reg  [21:0] addr;
  reg  [15:0] wdata;
  reg  [15:0] rdata;
  reg         busy;
  reg         in_bypass;
  reg         in_secure;
  reg         in_asel;
  reg         tlim;
  reg         refused;
  reg         accel;
  reg         word_mode;
  reg         hw_reset;
  reg         cyc_start;
  reg         cyc_write;
  reg  [21:0] cyc_addr;
  reg  [15:0] cyc_data;
  wire        cyc_done;
  wire [15:0] cyc_rdata;
  wire [21:0] bank;
  wire        wb_req;

  assign bank        = addr & `FCS_BANK_MASK;
  assign wb_req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign fl_byte_n_o = word_mode;

  // Cycle count of each command sequence
  function [2:0] seq_len;
    input [3:0] o;
    begin
      case (o)
        `FCS_OP_RESET:    seq_len = 3'h1;
        `FCS_OP_READ:     seq_len = 3'h1;
        `FCS_OP_ASEL:     seq_len = 3'h3;
        `FCS_OP_SEC_IN:   seq_len = 3'h3;
        `FCS_OP_SEC_OUT:  seq_len = 3'h4;
        `FCS_OP_PROG:     seq_len = 3'h4;
        `FCS_OP_BYP_IN:   seq_len = 3'h3;
        `FCS_OP_BYP_PROG: seq_len = 3'h2;
        `FCS_OP_BYP_OUT:  seq_len = 3'h2;
        `FCS_OP_CHIP_ER:  seq_len = 3'h6;
        default:          seq_len = 3'h0;
      endcase
    end
  endfunction

  // Whether the operation may start from the present state
  function allowed;
    input [3:0] o;
    input       b;
    input       byp;
    input       sec;
    begin
      case (o)
        `FCS_OP_RESET:    allowed = ~b | tlim;                   // [R5] [R25]
        `FCS_OP_READ:     allowed = ~b;                          // [R3] [R4]
        `FCS_OP_ASEL:     allowed = ~b & ~byp;                   // [R2] [R12]
        `FCS_OP_SEC_IN:   allowed = ~b & ~byp;                   // [R7] [R12]
        `FCS_OP_SEC_OUT:  allowed = ~b & sec;                    // [R6]
        `FCS_OP_PROG:     allowed = ~b & ~byp;                   // [R11] [R14]
        `FCS_OP_BYP_IN:   allowed = ~b & ~sec & ~byp;            // [R8]
        `FCS_OP_BYP_PROG: allowed = ~b & byp & ~sec;             // [R16] [R17]
        `FCS_OP_BYP_OUT:  allowed = ~b & byp & ~accel;           // [R17]
        `FCS_OP_CHIP_ER:  allowed = ~b & ~byp & ~sec;            // [R22]
        default:          allowed = 1'b0;
      endcase
    end
  endfunction

  // Address and data of each sequence step
  always @* begin
    cyc_write = 1'b1;
    cyc_addr  = `FCS_UNLOCK_A1;
    cyc_data  = `FCS_UNLOCK_D1;
    case (op)
      `FCS_OP_RESET: begin
        cyc_data = `FCS_CMD_RESET;                               // [R5] [R24]
      end
      `FCS_OP_READ: begin
        cyc_write = 1'b0;
        cyc_addr  = addr;
      end
      `FCS_OP_BYP_PROG: begin
        cyc_addr = (step == 3'h0) ? bank : addr;
        cyc_data = (step == 3'h0) ? `FCS_CMD_PROG : wdata;       // [R16]
      end
      `FCS_OP_BYP_OUT: begin
        cyc_addr = bank;
        cyc_data = (step == 3'h0) ? `FCS_BYP_OUT1 : `FCS_CMD_SEC_OUT;
      end
      default: begin
        if (step == 3'h1 || step == 3'h4) begin
          cyc_addr = `FCS_UNLOCK_A2;
          cyc_data = `FCS_UNLOCK_D2;
        end else if (step == 3'h2) begin
          cyc_addr = bank | `FCS_UNLOCK_A1;
          case (op)
            `FCS_OP_ASEL:    cyc_data = `FCS_CMD_ASEL;           // [R1]
            `FCS_OP_SEC_IN:  cyc_data = `FCS_CMD_SEC_IN;         // [R6]
            `FCS_OP_SEC_OUT: cyc_data = `FCS_CMD_ASEL;
            `FCS_OP_PROG:    cyc_data = `FCS_CMD_PROG;           // [R9]
            `FCS_OP_BYP_IN:  cyc_data = `FCS_CMD_BYPASS;         // [R15]
            default:         cyc_data = `FCS_CMD_ERASE;          // [R19]
          endcase
        end else if (step == 3'h3) begin
          cyc_addr = (op == `FCS_OP_PROG) ? addr : `FCS_UNLOCK_A1;
          cyc_data = (op == `FCS_OP_PROG) ? wdata :               // [R13]
                     (op == `FCS_OP_SEC_OUT) ? `FCS_CMD_SEC_OUT : `FCS_UNLOCK_D1;
        end else if (step == 3'h5) begin
          cyc_data = `FCS_CMD_CHIP;
        end
      end
    endcase
  end

  fcs_bus_cycle u_cycle (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .start_i    (cyc_start),
    .write_i    (cyc_write),
    .addr_i     (cyc_addr),
    .data_i     (cyc_data),
    .done_o     (cyc_done),
    .rdata_o    (cyc_rdata),
    .fl_addr_o  (fl_addr_o),
    .fl_dq_o    (fl_dq_o),
    .fl_dq_oe_o (fl_dq_oe_o),
    .fl_dq_i    (fl_dq_i),
    .fl_ce_n_o  (fl_ce_n_o),
    .fl_we_n_o  (fl_we_n_o),
    .fl_oe_n_o  (fl_oe_n_o)
  );

  // Sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state     <= S_IDLE;
      op        <= 4'h0;
      step      <= 3'h0;
      nsteps    <= 3'h0;
      busy      <= 1'b0;
      in_bypass <= 1'b0;
      in_secure <= 1'b0;
      in_asel   <= 1'b0;
      tlim      <= 1'b0;
      refused   <= 1'b0;
      rdata     <= 16'h0000;
      cyc_start <= 1'b0;
    end else begin
      cyc_start <= 1'b0;
      if (hw_reset) begin
        // Hardware reset aborts any algorithm [R11] [R22]
        state     <= S_IDLE;
        busy      <= 1'b0;
        in_bypass <= 1'b0;
        in_secure <= 1'b0;
        in_asel   <= 1'b0;
      end else begin
        if (accel && !in_secure) begin
          in_bypass <= 1'b1;                                     // [R18]
        end
        case (state)
          S_IDLE: begin
            if (wb_req && wb_we_i && wb_adr_i == `FCS_ADR_CTRL && wb_sel_i[0]) begin
              if (allowed(wb_dat_i[3:0], busy, in_bypass, in_secure)) begin
                op      <= wb_dat_i[3:0];
                nsteps  <= seq_len(wb_dat_i[3:0]);
                step    <= 3'h0;
                refused <= 1'b0;
                state   <= S_LOAD;
              end else begin
                refused <= 1'b1;
              end
            end else if (busy && ready_busy_output_i) begin
              busy <= 1'b0;                                      // [R10] [R21]
            end
          end
          S_LOAD: begin
            cyc_start <= 1'b1;
            state     <= S_CYC;
          end
          S_CYC: begin
            if (cyc_done) begin
              if (step == nsteps - 3'h1) begin
                state <= S_WAIT;
              end else begin
                step  <= step + 3'h1;
                state <= S_LOAD;
              end
            end
          end
          S_WAIT: begin
            state <= S_IDLE;
            case (op)
              `FCS_OP_READ: begin
                rdata <= cyc_rdata;
                if (busy && cyc_rdata[5]) begin
                  tlim <= 1'b1;                                  // [R25]
                end
              end
              `FCS_OP_RESET: begin
                in_asel <= 1'b0;                                 // [R5]
                tlim    <= 1'b0;
                busy    <= 1'b0;
              end
              `FCS_OP_ASEL:    in_asel   <= 1'b1;                // [R1]
              `FCS_OP_SEC_IN:  in_secure <= 1'b1;                // [R6]
              `FCS_OP_SEC_OUT: in_secure <= 1'b0;
              `FCS_OP_BYP_IN:  in_bypass <= 1'b1;                // [R15]
              `FCS_OP_BYP_OUT: in_bypass <= 1'b0;                // [R17]
              default:         busy      <= 1'b1;                // [R20]
            endcase
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // Wishbone slave, one wait state
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o            <= 1'b0;
      wb_dat_o            <= 32'h00000000;
      addr                <= 22'h000000;
      wdata               <= 16'h0000;
      accel               <= 1'b0;
      word_mode           <= 1'b1;
      hw_reset            <= 1'b0;
      protect_accel_pin_o <= 1'b0;
      fl_reset_n_o        <= 1'b0;
    end else begin
      wb_ack_o            <= wb_req;
      hw_reset            <= 1'b0;
      fl_reset_n_o        <= ~hw_reset;
      protect_accel_pin_o <= accel & ~in_secure;                 // [R8] [R18]
      wb_dat_o            <= 32'h00000000;
      if (wb_req && wb_we_i) begin
        case (wb_adr_i)
          `FCS_ADR_CTRL: begin
            if (wb_sel_i[1]) begin
              accel     <= wb_dat_i[8];
              word_mode <= wb_dat_i[9];
              hw_reset  <= wb_dat_i[10];
            end
          end
          `FCS_ADR_ADDR: addr  <= wb_dat_i[21:0];
          `FCS_ADR_DATA: wdata <= wb_dat_i[15:0];
          default: ;
        endcase
      end else if (wb_req) begin
        case (wb_adr_i)
          `FCS_ADR_CTRL:  wb_dat_o <= {21'h000000, hw_reset, word_mode, accel, 4'h0, op};
          `FCS_ADR_ADDR:  wb_dat_o <= {10'h000, addr};
          `FCS_ADR_DATA:  wdata    <= wdata;
          `FCS_ADR_STAT:  wb_dat_o <= {24'h000000, refused, accel, ready_busy_output_i, tlim,
                                       in_asel, in_secure, in_bypass, busy | (state != S_IDLE)};
          `FCS_ADR_RDATA: wb_dat_o <= {16'h0000, rdata};
          default:        wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

/* File: fcs_map.vh */
// Constants for the flash command sequencer host controller
// Assumes a 200 MHz clock and a parallel NOR flash on plain pins
`ifndef FCS_MAP_VH
`define FCS_MAP_VH
`define FCS_ADR_CTRL     4'h0
`define FCS_ADR_ADDR     4'h1
`define FCS_ADR_DATA     4'h2
`define FCS_ADR_STAT     4'h3
`define FCS_ADR_RDATA    4'h4
`define FCS_OP_RESET     4'h1
`define FCS_OP_ASEL      4'h2
`define FCS_OP_SEC_IN    4'h3
`define FCS_OP_SEC_OUT   4'h4
`define FCS_OP_PROG      4'h5
`define FCS_OP_BYP_IN    4'h6
`define FCS_OP_BYP_PROG  4'h7
`define FCS_OP_BYP_OUT   4'h8
`define FCS_OP_CHIP_ER   4'h9
`define FCS_OP_READ      4'ha
`define FCS_UNLOCK_A1    22'h000555
`define FCS_UNLOCK_A2    22'h0002aa
`define FCS_UNLOCK_D1    16'h00aa
`define FCS_UNLOCK_D2    16'h0055
`define FCS_CMD_RESET    16'h00f0
`define FCS_CMD_ASEL     16'h0090
`define FCS_CMD_SEC_IN   16'h0088
`define FCS_CMD_SEC_OUT  16'h0000
`define FCS_CMD_PROG     16'h00a0
`define FCS_CMD_BYPASS   16'h0020
`define FCS_CMD_ERASE    16'h0080
`define FCS_CMD_CHIP     16'h0010
`define FCS_BYP_OUT1     16'h0090
`define FCS_BANK_MASK    22'h3f8000
`define FCS_PHASE_CYC    3'h4
`define FCS_ST_BUSY      0
`define FCS_ST_BYP       1
`define FCS_ST_SEC       2
`define FCS_ST_ASEL      3
`define FCS_ST_TLIM      4
`define FCS_ST_RDY       5
`define FCS_ST_ACC       6
`endif

/* File: fcs_bus_cycle.v */
// One flash bus cycle: write or read on the parallel pins
// Assumes the flash samples address on falling and data on rising write enable
`timescale 1ns/1ps
`include "fcs_map.vh"
module fcs_bus_cycle (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        start_i,
  input  wire        write_i,
  input  wire [21:0] addr_i,
  input  wire [15:0] data_i,
  output wire        done_o,
  output reg  [15:0] rdata_o,
  output reg  [21:0] fl_addr_o,
  output reg  [15:0] fl_dq_o,
  output reg         fl_dq_oe_o,
  input  wire [15:0] fl_dq_i,
  output reg         fl_ce_n_o,
  output reg         fl_we_n_o,
  output reg         fl_oe_n_o
);
  localparam S_IDLE = 3'b001;
  localparam S_SET  = 3'b010;
  localparam S_HOLD = 3'b100;
  reg [2:0] state;
  reg [2:0] cnt;
  assign done_o = (state == S_HOLD) && (cnt == 3'h0);
  always @(posedge clk_i) begin
    if (rst_i) begin
      state      <= S_IDLE;
      cnt        <= 3'h0;
      rdata_o    <= 16'h0000;
      fl_addr_o  <= 22'h000000;
      fl_dq_o    <= 16'h0000;
      fl_dq_oe_o <= 1'b0;
      fl_ce_n_o  <= 1'b1;
      fl_we_n_o  <= 1'b1;
      fl_oe_n_o  <= 1'b1;
    end else begin
      case (state)
        S_IDLE: begin
          if (start_i) begin
            fl_addr_o  <= addr_i;
            fl_dq_o    <= data_i;
            fl_dq_oe_o <= write_i;
            fl_ce_n_o  <= 1'b0;
            cnt        <= `FCS_PHASE_CYC;
            state      <= S_SET;
          end
        end
        S_SET: begin
          // Address captured on this falling strobe [R23]
          fl_we_n_o <= ~fl_dq_oe_o;
          fl_oe_n_o <= fl_dq_oe_o;
          cnt       <= `FCS_PHASE_CYC;
          state     <= S_HOLD;
        end
        S_HOLD: begin
          if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
          end else begin
            // Data captured on the rising strobe [R23]
            rdata_o    <= fl_dq_i;
            fl_we_n_o  <= 1'b1;
            fl_oe_n_o  <= 1'b1;
            fl_ce_n_o  <= 1'b1;
            fl_dq_oe_o <= 1'b0;
            state      <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

/* File: fcs_flash_model.sv */
// Behavioural banked NOR flash driven from its pins
// Assumes one host bus cycle at a time; clk samples the write strobe and times the busy period
`timescale 1ns/1ps
module fcs_flash_model #(
  parameter        BUSY_CYC = 40,
  parameter [15:0] ID_CODE  = 16'h0042, // Arbitrary value
  parameter [15:0] SEC_WORD = 16'h5a3c
) (
  input  wire        clk_i,
  input  wire [21:0] addr_i,
  input  wire [15:0] dq_i,
  input  wire        ce_n_i,
  input  wire        we_n_i,
  input  wire        oe_n_i,
  input  wire        acc_i,
  input  wire        rst_n_i,
  output wire [15:0] dq_o,
  output wire        rb_o
);
  reg [15:0] mem [0:15];
  reg [21:0] a;
  reg [15:0] last;
  reg [7:0]  bc;
  reg [3:0]  st;
  reg        wq;
  reg        byp;
  reg        sec;
  reg        asel;
  integer    i;
  wire       bp = byp | (acc_i & ~sec); // Accel forces bypass, never while secured
  wire       drv = ~ce_n_i & ~oe_n_i;
  wire [15:0] rd = (bc != 8'h00) ? {9'h000, ~last[6], 6'h00} : asel ? ID_CODE :
                   sec ? SEC_WORD : mem[addr_i[3:0]];
  assign dq_o = drv ? rd : ~last;
  assign rb_o = (bc == 8'h00); // Busy until done
  initial begin
    for (i = 0; i < 16; i = i + 1)
      mem[i] = 16'hffff;
    {a, last, bc, st, wq, byp, sec, asel} = 0;
  end
  task step(input [21:0] ad, input [15:0] d);
    begin
      st <= 4'h0; // Mismatch abandons the sequence
      if (d == 16'h00f0 && !bp)
        asel <= 1'b0; // Reset command
      else case (st)
        4'h0: if (bp) begin
          st <= (d == 16'h00a0) ? 4'h6 : (d == 16'h0090) ? 4'h7 : 4'h0;
        end else if (ad[10:0] == 11'h555 && d == 16'h00aa)
          st <= 4'h1;
        4'h1: if (ad[10:0] == 11'h2aa && d == 16'h0055)
          st <= 4'h2;
        4'h2: case (d)
          16'h0090: if (sec) st <= 4'h5; else asel <= 1'b1;
          16'h0088: sec <= 1'b1;
          16'h0020: byp <= ~sec;
          16'h00a0: st <= 4'h3;
          16'h0080: st <= 4'h8;
          default: ;
        endcase
        4'h3, 4'h6: begin // Clears bits only, any order
          mem[ad[3:0]] <= mem[ad[3:0]] & d;
          bc <= BUSY_CYC;
        end
        4'h5: if (d == 16'h0000) sec <= 1'b0;
        4'h7: if (d == 16'h0000) byp <= 1'b0;
        4'h8: if (d == 16'h00aa) st <= 4'h9;
        4'h9: if (d == 16'h0055) st <= 4'ha;
        4'ha: if (d == 16'h0010) begin // Internal preprogram then erase
          for (i = 0; i < 16; i = i + 1)
            mem[i] <= 16'hffff;
          bc <= BUSY_CYC;
        end
        default: ;
      endcase
    end
  endtask
  always @(posedge clk_i) begin
    wq <= we_n_i;
    if (drv)
      last <= rd;
    if (bc != 8'h00)
      bc <= bc - 8'h01;
    if (wq && !we_n_i)
      a <= addr_i; // Address on falling strobe, data on rising
    if (!rst_n_i) begin // Hardware reset aborts
      {bc, st, byp, asel} <= 0;
    end else if (!wq && we_n_i && bc == 8'h00) // Writes ignored while busy
      step(a, dq_i);
  end
endmodule

/* File: fcs_host_monitor.sv */
// Port checker for the flash command sequencer host controller
// Assumes binding to fcs_host; one clock, sync active-high reset
`timescale 1ns/1ps
module fcs_host_monitor (
  input wire        clk_i,
  input wire        rst_i,
  input wire [3:0]  wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_we_i,
  input wire [3:0]  wb_sel_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [21:0] fl_addr_o,
  input wire [15:0] fl_dq_o,
  input wire        fl_dq_oe_o,
  input wire [15:0] fl_dq_i,
  input wire        fl_ce_n_o,
  input wire        fl_we_n_o,
  input wire        fl_oe_n_o,
  input wire        fl_byte_n_o,
  input wire        protect_accel_pin_o,
  input wire        fl_reset_n_o,
  input wire        ready_busy_output_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ctrl_wr;
    s_req ##0 (wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[1]);
  endsequence
  sequence s_pulse;
    (!fl_we_n_o && !fl_ce_n_o) [*4] ##[1:4] (fl_we_n_o && fl_ce_n_o);
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_we_frame: assert property ($fell(fl_we_n_o) |-> s_pulse)
    else $error("write strobe malformed");
  a_write_hold: assert property (!fl_we_n_o && $past(!fl_we_n_o) |->
    $stable(fl_addr_o) && $stable(fl_dq_o) && fl_dq_oe_o)
    else $error("address or data moved in write");
  a_read_clean: assert property (!fl_oe_n_o |-> !fl_dq_oe_o && fl_we_n_o && !fl_ce_n_o)
    else $error("read strobe with bus driven");
  a_word_mode: assert property (s_ctrl_wr |=> fl_byte_n_o == $past(wb_dat_i[9]))
    else $error("word mode not taken");
  a_accel_off: assert property (s_ctrl_wr ##0 !wb_dat_i[8] |=> ##1 !protect_accel_pin_o)
    else $error("accel not dropped");
  a_rst_pulse: assert property ($fell(fl_reset_n_o) |=> fl_reset_n_o)
    else $error("reset pulse not one cycle");
endmodule

/* File: testbench.sv */
// Self-checking bench: Wishbone master against fcs_host and a flash model
// Assumes the register map and ops of fcs_map.vh
`timescale 1ns/1ps
`include "fcs_map.vh"
`define CHK(g, e) begin num_checks = num_checks + 1; if ((g) !== (e)) begin errors = errors + 1; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module testbench;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg  [3:0]  wb_adr_i = 4'h0;
  reg  [31:0] wb_dat_i = 32'h0;
  reg         wb_we_i = 1'b0;
  reg  [3:0]  wb_sel_i = 4'h0;
  reg         wb_cyc_i = 1'b0;
  reg         wb_stb_i = 1'b0;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o;
  wire [21:0] fl_addr_o;
  wire [15:0] fl_dq_o;
  wire [15:0] fl_dq_i;
  wire        fl_dq_oe_o;
  wire        fl_ce_n_o;
  wire        fl_we_n_o;
  wire        fl_oe_n_o;
  wire        fl_byte_n_o;
  wire        protect_accel_pin_o;
  wire        fl_reset_n_o;
  wire        ready_busy_output_i;
  reg  [31:0] rdat;
  integer     errors = 0;
  integer     num_checks = 0;
  integer     ticks = 0;
  always #2.5 clk_i = ~clk_i;
  fcs_host dut (.*);
  fcs_flash_model u_flash (.clk_i(clk_i), .addr_i(fl_addr_o), .dq_i(fl_dq_o), .ce_n_i(fl_ce_n_o),
    .we_n_i(fl_we_n_o), .oe_n_i(fl_oe_n_o), .acc_i(protect_accel_pin_o), .rst_n_i(fl_reset_n_o),
    .dq_o(fl_dq_i), .rb_o(ready_busy_output_i));
  task complete_run;
    begin
      if (errors == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk_i) begin
    ticks = ticks + 1;
    if (ticks == 40000) begin
      errors = errors + 1;
      complete_run;
    end
  end
  task wb(input w, input [3:0] ad, input [31:0] d, input [3:0] s);
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= ad;
      wb_dat_i <= d;
      wb_sel_i <= s;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
        @(posedge clk_i);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task op(input [3:0] o);
    begin
      wb(1'b1, `FCS_ADR_CTRL, {28'h0, o}, 4'h1);
      repeat (3) @(posedge clk_i);
      rdat = 32'h1;
      while (rdat[0] !== 1'b0)
        wb(1'b0, `FCS_ADR_STAT, 32'h0, 4'hf);
    end
  endtask
  task prog(input [3:0] o, input [21:0] ad, input [15:0] d);
    begin
      wb(1'b1, `FCS_ADR_ADDR, {10'h0, ad}, 4'hf);
      wb(1'b1, `FCS_ADR_DATA, {16'h0, d}, 4'hf);
      op(o);
    end
  endtask
  task rdc(input [21:0] ad, input [15:0] e);
    begin
      wb(1'b1, `FCS_ADR_ADDR, {10'h0, ad}, 4'hf);
      op(`FCS_OP_READ);
      wb(1'b0, `FCS_ADR_RDATA, 32'h0, 4'hf);
      `CHK(rdat[15:0], e)
    end
  endtask
  task stc(input integer b, input e);
    begin
      wb(1'b0, `FCS_ADR_STAT, 32'h0, 4'hf);
      `CHK(rdat[b], e)
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, `FCS_ADR_CTRL, 32'h400, 4'h2);
    wb(1'b1, `FCS_ADR_CTRL, 32'h200, 4'h2);
    wb(1'b0, 4'h7, 32'h0, 4'hf);
    `CHK(rdat, 32'h0)
    stc(`FCS_ST_RDY, 1'b1);
    prog(`FCS_OP_PROG, 22'h000003, 16'h1234);
    rdc(22'h000003, 16'h1234);
    prog(`FCS_OP_PROG, 22'h000003, 16'h00ff);
    rdc(22'h000003, 16'h0034);
    prog(`FCS_OP_PROG, 22'h20000c, 16'h5678);
    rdc(22'h20000c, 16'h5678);
    op(`FCS_OP_ASEL);
    stc(`FCS_ST_ASEL, 1'b1);
    rdc(22'h000000, u_flash.ID_CODE);
    rdc(22'h000005, u_flash.ID_CODE);
    op(`FCS_OP_RESET);
    rdc(22'h000003, 16'h0034);
    op(`FCS_OP_SEC_IN);
    rdc(22'h000003, u_flash.SEC_WORD);
    op(`FCS_OP_BYP_IN);
    stc(7, 1'b1);
    stc(`FCS_ST_BYP, 1'b0);
    op(`FCS_OP_SEC_OUT);
    rdc(22'h000003, 16'h0034);
    op(`FCS_OP_BYP_IN);
    stc(`FCS_ST_BYP, 1'b1);
    prog(`FCS_OP_BYP_PROG, 22'h000004, 16'h0f0f);
    prog(`FCS_OP_BYP_PROG, 22'h000005, 16'hf0f0);
    rdc(22'h000004, 16'h0f0f);
    rdc(22'h000005, 16'hf0f0);
    prog(`FCS_OP_PROG, 22'h000006, 16'h0000);
    rdc(22'h000006, 16'hffff);
    op(`FCS_OP_BYP_OUT);
    stc(`FCS_ST_BYP, 1'b0);
    wb(1'b1, `FCS_ADR_CTRL, 32'h300, 4'h2);
    @(posedge clk_i);
    `CHK(protect_accel_pin_o, 1'b1)
    prog(`FCS_OP_BYP_PROG, 22'h000007, 16'h00aa);
    rdc(22'h000007, 16'h00aa);
    wb(1'b1, `FCS_ADR_CTRL, 32'h200, 4'h2);
    op(`FCS_OP_BYP_OUT);
    stc(`FCS_ST_BYP, 1'b0);
    wb(1'b1, `FCS_ADR_ADDR, 32'h8, 4'hf);
    wb(1'b1, `FCS_ADR_DATA, 32'h0, 4'hf);
    wb(1'b1, `FCS_ADR_CTRL, {28'h0, `FCS_OP_PROG}, 4'h1);
    repeat (40) @(posedge clk_i);
    wb(1'b1, `FCS_ADR_CTRL, {28'h0, `FCS_OP_CHIP_ER}, 4'h1);
    stc(7, 1'b1);
    wb(1'b1, `FCS_ADR_CTRL, {28'h0, `FCS_OP_ASEL}, 4'h1);
    stc(`FCS_ST_ASEL, 1'b0);
    wb(1'b1, `FCS_ADR_CTRL, {28'h0, `FCS_OP_SEC_IN}, 4'h1);
    stc(`FCS_ST_SEC, 1'b0);
    stc(`FCS_ST_BUSY, 1'b1);
    op(`FCS_OP_RESET);
    rdc(22'h000003, 16'h0034);
    rdc(22'h000008, 16'h0000);
    op(`FCS_OP_CHIP_ER);
    stc(`FCS_ST_RDY, 1'b1);
    rdc(22'h000003, 16'hffff);
    rdc(22'h000008, 16'hffff);
    complete_run;
  end
endmodule
bind fcs_host fcs_host_monitor u_mon (.*);
